// ==== inc/ecl_pkg.sv ====
// Constants shared by the command link, its link port and the checksum unit
package ecl_pkg;
	localparam int WORD_W = 32;
	localparam int HALF_W = 16;
	localparam logic [15:0] OP_READ = 16'h0001;
	localparam logic [15:0] OP_EXEC_VERSION = 16'h0007;
	localparam logic [15:0] OP_GET_CRC = 16'h0008;
	localparam logic [15:0] OP_LAST = 16'h000d;
	localparam logic [15:0] RSP_PASS = 16'h0000;
	localparam logic [15:0] RSP_FAIL = 16'h0002;
	localparam logic [15:0] RSP_UNKNOWN_CMD_REPLY = 16'h0003;
	localparam int CTRL_PROCESSOR_ACCESS_PENDING_BIT = 18;
	localparam logic [31:0] FAST_DATA_ADDR = 32'hff200000;
	localparam logic [31:0] WORD_STEP = 32'h00000004;
	localparam logic [1:0] SEL_CONTROL = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_FASTDATA = 2'h2;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'h1021;
	localparam logic [15:0] EXEC_VERSION_DEF = 16'h0100;
	localparam int OSC_HZ = 8000000;
endpackage

// ==== inc/ecl_word_if.sv ====
// Word and toggle carrier between the link-clock port and the core
`timescale 1ns/1ps
`default_nettype none
interface ecl_word_if;
	logic [31:0] cmd_word;
	logic cmd_tgl;
	logic ack_tgl;
	logic [31:0] rsp_word;
	logic rsp_tgl;
	logic [31:0] ret_word;
	logic ret_tgl;
	modport link (output cmd_word, output cmd_tgl, output ack_tgl, input rsp_word, input rsp_tgl,
		input ret_word, input ret_tgl);
	modport core (input cmd_word, input cmd_tgl, input ack_tgl, output rsp_word, output rsp_tgl,
		output ret_word, output ret_tgl);
endinterface
`default_nettype wire

// ==== src/ecl_crc_unit.sv ====
// Running CRC over 32-bit words, one word per clock
`timescale 1ns/1ps
`default_nettype none
module ecl_crc_unit import ecl_pkg::*; #(
	parameter logic [15:0] POLY = CRC_POLY,
	parameter logic [15:0] INIT = CRC_INIT
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic clear_in,
	input wire logic valid_in,
	input wire logic [31:0] word_in,
	output logic [15:0] crc_out
);
	typedef struct packed {
		logic [15:0] crc;
	} ecl_crc_s;

	ecl_crc_s s_q, s_d;

	// MSB first, whole word in one step
	function automatic logic [15:0] ecl_crc_word(input logic [15:0] c, input logic [31:0] w);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			if (r[15] ^ w[i]) begin
				r = {r[14:0], 1'b0} ^ POLY;
			end else begin
				r = {r[14:0], 1'b0};
			end
		end
		return r;
	endfunction

	always_comb begin
		s_d = s_q;
		if (clear_in) begin
			s_d.crc = INIT;
		end else if (valid_in) begin
			s_d.crc = ecl_crc_word(s_q.crc, word_in);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '{crc: INIT};
		end else begin
			s_q <= s_d;
		end
	end

	assign crc_out = s_q.crc;
endmodule
`default_nettype wire

// ==== src/ecl_exec_core.sv ====
// Command interpreter of the flash loader firmware link with memory verify
// -----------------------------------------------------------------------
// Functional notes
// - CPU store to fast-data location is readable
// - One command at a time, one response word per access release
// - Commands in fast-data, responses via data
// - Header: opcode high half, operand low
// - Operand always sent, ignored if unused
// - Unknown opcode answered not-recognised
// - Operand gives read word count; checksum length comes in a byte-count word
// - Every command gets a status response
// - Read data words follow the header
// - Core runs from internal fast oscillator
// - Codes: pass 0, fail 2, unknown 3
// - Header: last command high, code low
// - Checksum query opcode is 8
// -----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ecl_exec_core import ecl_pkg::*; #(
	parameter logic [15:0] EXEC_VERSION = EXEC_VERSION_DEF // Arbitrary value
) (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic link_clk_in,
	input wire logic [1:0] link_sel_in,
	input wire logic link_capture_in,
	input wire logic link_shift_in,
	input wire logic link_update_in,
	input wire logic link_tdi_in,
	output logic link_tdo_out,
	output logic link_pending_out,
	output logic mem_rd_out,
	output logic [31:0] mem_addr_out,
	input wire logic [31:0] mem_data_in,
	input wire logic cpu_store_in,
	input wire logic [31:0] cpu_store_addr_in,
	input wire logic [31:0] cpu_store_data_in,
	output logic busy_out,
	output logic [15:0] last_cmd_out
);
	// -------------------------------------------------------------------
	// State
	// -------------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_LEN,
		ST_RD_REQ,
		ST_RD_WAIT,
		ST_CRC_REQ,
		ST_CRC_WAIT,
		ST_CRC_DONE,
		ST_CRC_ZERO,
		ST_WAIT_ACK
	} ecl_state_e;

	typedef struct packed {
		logic cmd_s1;
		logic cmd_s2;
		logic cmd_seen;
		logic ack_s1;
		logic ack_s2;
		logic ack_seen;
		ecl_state_e state;
		logic [15:0] opcode;
		logic [15:0] operand;
		logic [31:0] addr;
		logic [31:0] count;
		logic [31:0] rsp_word;
		logic rsp_tgl;
		logic [31:0] ret_word;
		logic ret_tgl;
		logic mem_rd;
		logic [31:0] mem_addr;
		logic crc_clear;
		logic crc_valid;
	} ecl_core_s;

	ecl_core_s s_q, s_d;
	ecl_word_if wif ();
	logic [15:0] crc;
	// Toggle edges, one core cycle each
	logic word_ev;
	logic ack_ev;
	logic [15:0] rx_op;

	function automatic logic [31:0] ecl_header(input logic [15:0] op, input logic [15:0] code);
		return {op, code};
	endfunction

	// Byte length rounded up to whole words
	function automatic logic [31:0] ecl_word_count(input logic [31:0] bytes);
		return {2'b00, bytes[31:2]} + {31'h0, |bytes[1:0]};
	endfunction

	// Zero-word reads cannot complete
	function automatic logic ecl_bad_operand(input logic [15:0] op, input logic [15:0] operand);
		return op == OP_READ && operand == 16'h0000;
	endfunction

	// Opcodes past the command set get the unknown reply
	function automatic logic ecl_is_unknown(input logic [15:0] op);
		return op > OP_LAST;
	endfunction

	// -------------------------------------------------------------------
	// Link side and checksum
	// -------------------------------------------------------------------
	ecl_link_port u_link (
		.link_clk_in(link_clk_in),
		.reset_in(reset_in),
		.sel_in(link_sel_in),
		.capture_in(link_capture_in),
		.shift_in(link_shift_in),
		.update_in(link_update_in),
		.tdi_in(link_tdi_in),
		.tdo_out(link_tdo_out),
		.pending_out(link_pending_out),
		.w(wif.link)
	);

	ecl_crc_unit u_crc (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.clear_in(s_q.crc_clear),
		.valid_in(s_q.crc_valid),
		.word_in(mem_data_in),
		.crc_out(crc)
	);

	assign word_ev = s_q.cmd_s2 != s_q.cmd_seen;
	assign ack_ev = s_q.ack_s2 != s_q.ack_seen;
	assign rx_op = wif.cmd_word[31:16];

	// -------------------------------------------------------------------
	// Command interpreter
	// -------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.cmd_s1 = wif.cmd_tgl;
		s_d.cmd_s2 = s_q.cmd_s1;
		s_d.ack_s1 = wif.ack_tgl;
		s_d.ack_s2 = s_q.ack_s1;
		s_d.ack_seen = s_q.ack_s2;
		// Words that arrive in a state that does not wait for one are dropped, not queued
		s_d.cmd_seen = s_q.cmd_s2;
		s_d.mem_rd = 1'b0;
		s_d.crc_clear = 1'b0;
		s_d.crc_valid = 1'b0;
		// CPU stores to the fast-data location are returned through fast-data
		if (cpu_store_in && cpu_store_addr_in == FAST_DATA_ADDR) begin
			s_d.ret_word = cpu_store_data_in;
			s_d.ret_tgl = ~s_q.ret_tgl;
		end
		case (s_q.state)
			ST_IDLE: begin
				if (word_ev) begin
					s_d.opcode = rx_op;
					s_d.operand = wif.cmd_word[15:0];
					s_d.count = '0;
					if (ecl_is_unknown(rx_op)) begin
						s_d.rsp_word = ecl_header(rx_op, RSP_UNKNOWN_CMD_REPLY);
						s_d.rsp_tgl = ~s_q.rsp_tgl;
						s_d.state = ST_WAIT_ACK;
					end else if (ecl_bad_operand(rx_op, wif.cmd_word[15:0])) begin
						s_d.rsp_word = ecl_header(rx_op, RSP_FAIL);
						s_d.rsp_tgl = ~s_q.rsp_tgl;
						s_d.state = ST_WAIT_ACK;
					end else if (rx_op == OP_READ || rx_op == OP_GET_CRC) begin
						s_d.state = ST_ADDR;
					end else if (rx_op == OP_EXEC_VERSION) begin
						// Operand carries nothing for this command
						s_d.count = 32'h00000001;
						s_d.rsp_word = ecl_header(rx_op, RSP_PASS);
						s_d.rsp_tgl = ~s_q.rsp_tgl;
						s_d.state = ST_WAIT_ACK;
					end else begin
						// No flash write path here: known but unsupported commands fail
						s_d.rsp_word = ecl_header(rx_op, RSP_FAIL);
						s_d.rsp_tgl = ~s_q.rsp_tgl;
						s_d.state = ST_WAIT_ACK;
					end
				end
			end
			ST_ADDR: begin
				if (word_ev) begin
					s_d.addr = wif.cmd_word;
					if (s_q.opcode == OP_READ) begin
						s_d.count = {16'h0000, s_q.operand};
						s_d.rsp_word = ecl_header(s_q.opcode, RSP_PASS);
						s_d.rsp_tgl = ~s_q.rsp_tgl;
						s_d.state = ST_WAIT_ACK;
					end else begin
						s_d.state = ST_LEN;
					end
				end
			end
			ST_LEN: begin
				if (word_ev) begin
					// Length counts bytes; a partial last word is still read
					s_d.count = ecl_word_count(wif.cmd_word);
					s_d.crc_clear = 1'b1;
					s_d.state = ST_CRC_REQ;
				end
			end
			ST_CRC_REQ: begin
				if (s_q.count == '0) begin
					s_d.state = ST_CRC_DONE;
				end else begin
					s_d.mem_rd = 1'b1;
					s_d.mem_addr = s_q.addr;
					s_d.state = ST_CRC_WAIT;
				end
			end
			ST_CRC_WAIT: begin
				s_d.crc_valid = 1'b1;
				s_d.addr = s_q.addr + WORD_STEP;
				s_d.count = s_q.count - 32'h00000001;
				s_d.state = ST_CRC_REQ;
			end
			ST_CRC_DONE: begin
				// Checksum returns on the next fast-data transfer
				// A CPU store in this same cycle is lost to the checksum
				s_d.ret_word = {16'h0000, crc};
				s_d.ret_tgl = ~s_q.ret_tgl;
				s_d.state = ST_CRC_ZERO;
			end
			ST_CRC_ZERO: begin
				if (word_ev) begin
					s_d.rsp_word = ecl_header(s_q.opcode, RSP_PASS);
					s_d.rsp_tgl = ~s_q.rsp_tgl;
					s_d.state = ST_WAIT_ACK;
				end
			end
			ST_RD_REQ: begin
				s_d.mem_rd = 1'b1;
				s_d.mem_addr = s_q.addr;
				s_d.state = ST_RD_WAIT;
			end
			ST_RD_WAIT: begin
				s_d.rsp_word = mem_data_in;
				s_d.rsp_tgl = ~s_q.rsp_tgl;
				s_d.addr = s_q.addr + WORD_STEP;
				s_d.count = s_q.count - 32'h00000001;
				s_d.state = ST_WAIT_ACK;
			end
			ST_WAIT_ACK: begin
				if (ack_ev) begin
					if (s_q.opcode == OP_READ && s_q.count != '0) begin
						s_d.state = ST_RD_REQ;
					end else if (s_q.opcode == OP_EXEC_VERSION && s_q.count != '0) begin
						s_d.count = '0;
						s_d.rsp_word = {16'h0000, EXEC_VERSION};
						s_d.rsp_tgl = ~s_q.rsp_tgl;
					end else begin
						s_d.state = ST_IDLE;
					end
				end
			end
			default: begin
				s_d.state = ST_IDLE;
			end
		endcase
	end

	// -------------------------------------------------------------------
	// Registers
	// -------------------------------------------------------------------
	// Core clock stands for the internal fast oscillator
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			s_q <= '{state: ST_IDLE, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// -------------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------------
	assign wif.rsp_word = s_q.rsp_word;
	assign wif.rsp_tgl = s_q.rsp_tgl;
	assign wif.ret_word = s_q.ret_word;
	assign wif.ret_tgl = s_q.ret_tgl;
	assign mem_rd_out = s_q.mem_rd;
	assign mem_addr_out = s_q.mem_addr;
	assign busy_out = s_q.state != ST_IDLE;
	assign last_cmd_out = s_q.opcode;
endmodule
`default_nettype wire

// ==== src/ecl_link_port.sv ====
// Test-port registers on the link clock: control, data and fast-data
`timescale 1ns/1ps
`default_nettype none
module ecl_link_port import ecl_pkg::*; (
	input wire logic link_clk_in,
	input wire logic reset_in,
	input wire logic [1:0] sel_in,
	input wire logic capture_in,
	input wire logic shift_in,
	input wire logic update_in,
	input wire logic tdi_in,
	output logic tdo_out,
	output logic pending_out,
	ecl_word_if.link w
);
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic rsp_s1;
		logic rsp_s2;
		logic rsp_seen;
		logic ret_s1;
		logic ret_s2;
		logic ret_seen;
		logic [31:0] sh;
		logic [31:0] data;
		logic [31:0] ret;
		logic pending;
		logic [31:0] cmd_word;
		logic cmd_tgl;
		logic ack_tgl;
	} ecl_link_s;

	ecl_link_s s_q, s_d;

	always_comb begin
		s_d = s_q;
		// Reset and toggles cross in through two flops each
		s_d.rst_s1 = reset_in;
		s_d.rst_s2 = s_q.rst_s1;
		s_d.rsp_s1 = w.rsp_tgl;
		s_d.rsp_s2 = s_q.rsp_s1;
		s_d.ret_s1 = w.ret_tgl;
		s_d.ret_s2 = s_q.ret_s1;
		if (s_q.rst_s2) begin
			s_d.rsp_seen = s_q.rsp_s2;
			s_d.ret_seen = s_q.ret_s2;
			s_d.sh = '0;
			s_d.data = '0;
			s_d.ret = '0;
			s_d.pending = 1'b0;
			s_d.cmd_word = '0;
			s_d.cmd_tgl = 1'b0;
			s_d.ack_tgl = 1'b0;
		end else begin
			if (s_q.ret_s2 != s_q.ret_seen) begin
				s_d.ret_seen = s_q.ret_s2;
				s_d.ret = w.ret_word;
			end
			if (capture_in) begin
				if (sel_in == SEL_CONTROL) begin
					s_d.sh = '0;
					s_d.sh[CTRL_PROCESSOR_ACCESS_PENDING_BIT] = s_q.pending;
				end else if (sel_in == SEL_DATA) begin
					s_d.sh = s_q.data;
				end else if (sel_in == SEL_FASTDATA) begin
					s_d.sh = s_q.ret;
				end else begin
					s_d.sh = '0;
				end
			end else if (shift_in) begin
				s_d.sh = {tdi_in, s_q.sh[31:1]};
			end else if (update_in) begin
				if (sel_in == SEL_CONTROL) begin
					// Writing zero to the access bit lets the core go on
					if (!s_q.sh[CTRL_PROCESSOR_ACCESS_PENDING_BIT] && s_q.pending) begin
						s_d.pending = 1'b0;
						s_d.ack_tgl = ~s_q.ack_tgl;
					end
				end else if (sel_in == SEL_FASTDATA) begin
					s_d.cmd_word = s_q.sh;
					s_d.cmd_tgl = ~s_q.cmd_tgl;
				end
			end
			// Core word is held stable until released, so sampling it here is safe
			// Placed last so a new reply wins over a release in the same edge
			if (s_q.rsp_s2 != s_q.rsp_seen) begin
				s_d.rsp_seen = s_q.rsp_s2;
				s_d.data = w.rsp_word;
				s_d.pending = 1'b1;
			end
		end
	end

	// Link clock may stop between frames; nothing here needs a free-running edge
	always_ff @(posedge link_clk_in) begin
		s_q <= s_d;
	end

	assign tdo_out = s_q.sh[0];
	assign pending_out = s_q.pending;
	assign w.cmd_word = s_q.cmd_word;
	assign w.cmd_tgl = s_q.cmd_tgl;
	assign w.ack_tgl = s_q.ack_tgl;
endmodule
`default_nettype wire

// ==== testbench/ecl_prog_model.sv ====
// Programmer tool model driving the link test port
`timescale 1ns/1ps
`default_nettype none
module ecl_prog_model import ecl_pkg::*; (
	output logic link_clk_out,
	output logic [1:0] sel_out,
	output logic cap_out,
	output logic shift_out,
	output logic upd_out,
	output logic tdi_out,
	input wire logic tdo_in
);
	// ----------
	// Scan tasks
	// ----------
	logic master_reset_pin;
	logic high_voltage_level;
	initial begin
		master_reset_pin = 1'b0;
		high_voltage_level = 1'b1;
		link_clk_out = 1'b0;
		sel_out = 2'h3;
		cap_out = 1'b0;
		shift_out = 1'b0;
		upd_out = 1'b0;
		tdi_out = 1'b0;
	end
	// Clock runs only while tick is called: in scans, the exit sequence and bench waits
	task automatic tick(input int n);
		repeat (n) begin
			#62.5 link_clk_out = 1'b1;
			#62.5 link_clk_out = 1'b0;
		end
	endtask
	task automatic scan(input logic [1:0] s, input logic [31:0] di, input logic u, output logic [31:0] q);
		sel_out = s;
		cap_out = 1'b1;
		tick(1);
		cap_out = 1'b0;
		shift_out = 1'b1;
		for (int i = 0; i < 32; i++) begin
			tdi_out = di[i];
			q[i] = tdo_in;
			tick(1);
		end
		shift_out = 1'b0;
		upd_out = u;
		tick(1);
		upd_out = 1'b0;
		sel_out = 2'h3;
		// Released line shows no stale bit
		tdi_out = ~tdi_out;
	endtask
	// Mode pins are not modelled; five clocks with nothing selected stand for the ones
	task automatic exit_seq(input logic two_wire, input int exit_hold_interval);
		tick(5);
		master_reset_pin = 1'b1;
		if (two_wire) begin
			tick(1);
		end
		#(exit_hold_interval);
		high_voltage_level = 1'b0;
	endtask
	task automatic fast(input logic [31:0] w);
		logic [31:0] d;
		scan(SEL_FASTDATA, w, 1'b1, d);
	endtask
	// Caller reads every reply before the next command
	task automatic fetch(output logic [31:0] r, output logic ok);
		logic [31:0] c;
		ok = 1'b0;
		for (int n = 0; n < 40 && !ok; n++) begin
			scan(SEL_CONTROL, 32'h0004c000, 1'b1, c);
			ok = c[CTRL_PROCESSOR_ACCESS_PENDING_BIT];
		end
		scan(SEL_DATA, 32'h00000000, 1'b0, r);
		scan(SEL_CONTROL, 32'h0000c000, 1'b1, c);
	endtask
endmodule
`default_nettype wire

// ==== testbench/ecl_sva.sv ====
// Assertion checker for the command link core
`timescale 1ns/1ps
`default_nettype none
module ecl_sva import ecl_pkg::*; (
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic link_clk_in,
	input wire logic link_update_in,
	input wire logic link_pending_out,
	input wire logic mem_rd_out,
	input wire logic [31:0] mem_addr_out,
	input wire logic busy_out,
	input wire logic [15:0] last_cmd_out
);
	// ------
	// Checks
	// ------
	a_rd_pulse: assert property (@(posedge clk_in) disable iff (reset_in)
		mem_rd_out |=> !mem_rd_out) else $error("read strobe longer than one cycle");
	a_rd_busy: assert property (@(posedge clk_in) disable iff (reset_in)
		mem_rd_out |-> busy_out) else $error("read while idle");
	a_rd_data: assert property (@(posedge clk_in) disable iff (reset_in)
		mem_rd_out |=> busy_out) else $error("read data dropped");
	a_addr_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		mem_rd_out |=> $stable(mem_addr_out)) else $error("address moved before data");
	a_last_busy: assert property (@(posedge clk_in) disable iff (reset_in)
		$changed(last_cmd_out) |-> busy_out) else $error("last command changed while idle");
	// Address word always trails the header by a whole scan
	a_cmd_first: assert property (@(posedge clk_in) disable iff (reset_in)
		$rose(busy_out) |-> !mem_rd_out [*8]) else $error("read before address word");
	a_pend_hold: assert property (@(posedge link_clk_in) disable iff (reset_in)
		link_pending_out && !link_update_in && !$past(link_update_in) |=> link_pending_out)
		else $error("access flag dropped without release");
	a_pend_clear: assert property (@(posedge link_clk_in) disable iff (reset_in)
		// Spelled out so the unknown flag before link reset is no edge
		$past(link_pending_out) && !link_pending_out |-> $past(link_update_in) || $past(link_update_in, 2))
		else $error("access flag cleared without update");
	c_read: cover property (@(posedge clk_in) mem_rd_out);
	c_cmd: cover property (@(posedge clk_in) $rose(busy_out));
	c_pend: cover property (@(posedge link_clk_in) $rose(link_pending_out));
endmodule
bind ecl_exec_core ecl_sva u_sva (.clk_in(clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
	.link_update_in(link_update_in), .link_pending_out(link_pending_out), .mem_rd_out(mem_rd_out),
	.mem_addr_out(mem_addr_out), .busy_out(busy_out), .last_cmd_out(last_cmd_out));
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the command link core
`timescale 1ns/1ps
`default_nettype none
module tb import ecl_pkg::*; ;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic lclk, cap, shf, upd, tdi, tdo, pend, rd, busy;
	logic st;
	logic [1:0] sel;
	logic [31:0] addr, st_addr, st_data, mdata;
	logic [15:0] last_cmd;
	int error_cnt = 0;
	int tests_run = 0;
	// -------------
	// Harness
	// -------------
	always #25 clk_in = ~clk_in;
	ecl_exec_core DUT (.clk_in(clk_in), .reset_in(reset_in), .link_clk_in(lclk), .link_sel_in(sel),
		.link_capture_in(cap), .link_shift_in(shf), .link_update_in(upd), .link_tdi_in(tdi),
		.link_tdo_out(tdo), .link_pending_out(pend), .mem_rd_out(rd), .mem_addr_out(addr),
		.mem_data_in(mdata), .cpu_store_in(st), .cpu_store_addr_in(st_addr),
		.cpu_store_data_in(st_data), .busy_out(busy), .last_cmd_out(last_cmd));
	ecl_prog_model prog (.link_clk_out(lclk), .sel_out(sel), .cap_out(cap), .shift_out(shf),
		.upd_out(upd), .tdi_out(tdi), .tdo_in(tdo));
	// Memory contents follow from the address alone
	function automatic logic [31:0] memw(input logic [31:0] a);
		return {a[15:0], ~a[15:0]};
	endfunction
	assign mdata = memw(addr);
	function automatic logic [15:0] crc_w(input logic [15:0] c, input logic [31:0] w);
		logic [15:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CRC_POLY : 16'h0000);
		end
		return r;
	endfunction
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// A poll that never sees the access flag ends the run
	task automatic reply(input string nm, input logic [31:0] exp);
		logic [31:0] r;
		logic ok;
		prog.fetch(r, ok);
		if (!ok) begin
			error_cnt++;
			$display("CHECK FAILED %s expected flag 1 seen 0", nm);
			end_sim();
		end
		chk(nm, exp, r);
	endtask
	task automatic t_version();
		prog.fast({OP_EXEC_VERSION, 16'h5a5a});
		reply("version hdr", {OP_EXEC_VERSION, RSP_PASS});
		reply("version", {16'h0000, EXEC_VERSION_DEF});
		chk("last cmd", {16'h0000, OP_EXEC_VERSION}, {16'h0000, last_cmd});
		$display("test version done");
	endtask
	task automatic t_read();
		prog.fast({OP_READ, 16'h0003});
		prog.fast(32'h00001000);
		reply("read hdr", {OP_READ, RSP_PASS});
		for (int i = 0; i < 3; i++) begin
			reply("read word", memw(32'h00001000 + 32'(i * 4)));
		end
		$display("test read done");
	endtask
	task automatic t_crc();
		logic [15:0] c;
		logic [31:0] d;
		c = CRC_INIT;
		for (int i = 0; i < 4; i++) begin
			c = crc_w(c, memw(32'h00002000 + 32'(i * 4)));
		end
		prog.fast({OP_GET_CRC, 16'h0000});
		prog.fast(32'h00002000);
		prog.fast(32'h00000010);
		// Checksum needs len/4*2+3 core cycles plus the crossing
		repeat (20) @(posedge clk_in);
		// Checksum word crosses to the link side only on link edges
		prog.tick(4);
		prog.scan(SEL_FASTDATA, 32'h00000000, 1'b1, d);
		chk("checksum", {16'h0000, c}, d);
		reply("crc hdr", {OP_GET_CRC, RSP_PASS});
		$display("test crc done");
	endtask
	task automatic t_codes();
		logic [31:0] hdr [4] = '{32'h000e0000, 32'hffff1234, 32'h00040000, 32'h00010000};
		logic [15:0] code [4] = '{RSP_UNKNOWN_CMD_REPLY, RSP_UNKNOWN_CMD_REPLY, RSP_FAIL, RSP_FAIL};
		for (int i = 0; i < 4; i++) begin
			prog.fast(hdr[i]);
			reply("reply code", {hdr[i][31:16], code[i]});
		end
		$display("test codes done");
	endtask
	// CPU stand-in: lui sets the base, lw loads from t0, sw stores to the base
	task automatic t_store();
		logic [31:0] seq [3] = '{32'h3c13ff20, 32'h8d090000, 32'hae690000};
		logic [31:0] base;
		logic [31:0] t1;
		logic [31:0] d;
		base = 32'h00000000;
		t1 = 32'h00000000;
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_in);
			if (seq[i][31:26] == 6'h0f) begin
				base = {seq[i][15:0], 16'h0000};
			end else if (seq[i][31:26] == 6'h23) begin
				t1 = memw(32'h00003000 + 32'(seq[i][15:0]));
			end else if (seq[i][31:26] == 6'h2b) begin
				st <= 1'b1;
				st_addr <= base + 32'(seq[i][15:0]);
				st_data <= t1;
			end
		end
		@(posedge clk_in);
		st_addr <= base + WORD_STEP;
		st_data <= 32'h0bad0bad;
		@(posedge clk_in);
		st <= 1'b0;
		prog.tick(4);
		prog.scan(SEL_FASTDATA, 32'h00000000, 1'b0, d);
		chk("fast data word", memw(32'h00003000), d);
		$display("test store done");
	endtask
	task automatic t_exit();
		prog.exit_seq(1'b1, 2000);
		repeat (4) @(posedge clk_in);
		chk("idle after exit", 32'h00000000, {30'h0, busy, pend});
		$display("test exit done");
	endtask
	initial begin
		st <= 1'b0;
		st_addr <= 32'h00000000;
		st_data <= 32'h00000000;
		// Link side resets only on its own edges, so its clock runs during reset
		fork
			begin
				repeat (5) @(posedge clk_in);
				reset_in <= 1'b0;
			end
			prog.tick(2);
		join
		prog.tick(3);
		t_version();
		t_read();
		t_crc();
		t_codes();
		t_store();
		t_exit();
		end_sim();
	end
endmodule
`default_nettype wire
